// ===== verification/system_tick_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "system_tick_timer_consts.vh"
// Port-level watch on the tick timer
module system_tick_timer_chk (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	// Register port
	input wire logic [31:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	// State and interrupt
	input wire logic debug_halt_i,
	input wire logic ctrl_clk_stopped_i,
	input wire logic irq_o
);
	logic en_reg; // Shadow of the enable bit
	wire rcs = rd_i && addr_i == `TICK_CTRL_STATUS_ADDR; // Control read
	wire rcv = rd_i && addr_i == `TICK_CURRENT_VALUE_ADDR; // Count read
	wire wcv = wr_i && addr_i == `TICK_CURRENT_VALUE_ADDR; // Count write
	wire hold = !en_reg || debug_halt_i || ctrl_clk_stopped_i; // Counter frozen
	wire unm = addr_i[31:4] == 28'hE000E02 && addr_i[3]; // Unmapped words
	// Track enable from control writes
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en_reg <= 1'b0;
		end else if (wr_i && addr_i == `TICK_CTRL_STATUS_ADDR) begin
			en_reg <= wdata_i[0];
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not idle");
	AST_CTRL_FIXED: assert property (rcs |=> (rdata_o & 32'hFFFEFFFC) == 32'h4)
		else $error("control fixed bits wrong");
	AST_CALIB_FIXED: assert property (rd_i && addr_i == `TICK_CALIBRATION_ADDR
		|=> rdata_o[31:24] == 8'h80) else $error("calibration fixed bits wrong");
	AST_WIDTH: assert property ((rcv || rd_i && addr_i == `TICK_RELOAD_VALUE_ADDR)
		|=> rdata_o[31:24] == 8'h0) else $error("upper byte not zero");
	AST_UNMAPPED: assert property (rd_i && unm |=> rdata_o == 32'h0)
		else $error("unmapped read not zero");
	AST_HOLD: assert property (rcv && hold ##1 rcv |=> $stable(rdata_o))
		else $error("count moved while frozen");
	AST_DEC: assert property (rcv && !hold ##1 rcv |=> $past(rdata_o[23:0]) == 24'h0
		|| rdata_o[23:0] == $past(rdata_o[23:0]) - 24'h1) else $error("count not decremented");
	AST_FLAG_RDCLR: assert property (rcs && hold ##1 rcs |=> !rdata_o[16])
		else $error("flag survived read");
	AST_CUR_CLR: assert property (wcv ##1 hold ##1 rcv |=> rdata_o[23:0] == 24'h0)
		else $error("count not cleared");
	AST_CUR_FLAG: assert property (wcv ##2 rcs |=> !rdata_o[16])
		else $error("flag not cleared by count write");
	AST_IRQ_OFF: assert property (wr_i && (addr_i == `TICK_CTRL_STATUS_ADDR && !wdata_i[1]
		|| addr_i == `TICK_IRQ_MASK_ADDR && !wdata_i[0]) |-> ##2 !irq_o)
		else $error("interrupt stayed high");
endmodule // system_tick_timer_chk

bind system_tick_timer system_tick_timer_chk u_chk (.core_clk_i, .reset_n_i, .addr_i, .wdata_i,
	.wr_i, .rd_i, .rdata_o, .debug_halt_i, .ctrl_clk_stopped_i, .irq_o);
`default_nettype wire

// ===== verification/system_tick_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "system_tick_timer_consts.vh"
// Self-checking bench for the tick timer
module system_tick_timer_tb;
	localparam logic [31:0] CS = `TICK_CTRL_STATUS_ADDR; // Control/status
	localparam logic [31:0] RL = `TICK_RELOAD_VALUE_ADDR; // Reload
	localparam logic [31:0] CV = `TICK_CURRENT_VALUE_ADDR; // Count
	localparam logic [31:0] CB = `TICK_CALIBRATION_ADDR; // Calibration
	localparam logic [31:0] IS = `TICK_IRQ_STATUS_ADDR; // Interrupt status
	localparam logic [31:0] IM = `TICK_IRQ_MASK_ADDR; // Interrupt mask
	logic core_clk_i = 1'b0; // Core clock
	logic reset_n_i = 1'b0; // Reset, active low
	logic [31:0] addr_i = 32'h0; // Address
	logic [31:0] wdata_i = 32'h0; // Write data
	logic wr_i = 1'b0; // Write strobe
	logic rd_i = 1'b0; // Read strobe
	logic debug_halt_i = 1'b0; // Debug halt
	logic ctrl_clk_stopped_i = 1'b0; // Controller clock gated
	wire [31:0] rdata_o; // Read data
	wire irq_o; // Tick interrupt
	logic [31:0] v1, v2; // Two read results
	int num_errors = 0; // Mismatches
	int samples_checked = 0; // Comparisons
	int cyc = 0; // Rising edges seen
	int t1, t2; // Interrupt times
	system_tick_timer dut (.core_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.debug_halt_i, .ctrl_clk_stopped_i, .irq_o);
	// 10 MHz clock and edge count
	always #50 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) cyc <= cyc + 1;
	// Log one comparison
	task chk(input bit ok, input string m);
		samples_checked++;
		if (!ok) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// One-cycle register write
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask
	// Two back-to-back reads of one register
	task rd(input logic [31:0] a);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		v1 = rdata_o;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		@(negedge core_clk_i);
		v2 = rdata_o;
	endtask
	// Wait for the interrupt line, bounded
	task wait_irq(output int t);
		repeat (2) @(negedge core_clk_i);
		for (int i = 0; i < 40 && irq_o !== 1'b1; i++) begin
			@(negedge core_clk_i);
		end
		t = cyc;
		chk(irq_o === 1'b1, "no interrupt");
	endtask
	// Reset values and unmapped read
	task t_reset;
		rd(CS);
		chk(v1 === 32'h00000004, "ctrl reset");
		rd(RL);
		chk(v1 === 32'h005F7F9B, "reload reset");
		rd(CV);
		chk(v1 === 32'h007E7F35, "count reset");
		rd(CB);
		chk(v1 === 32'h800A71FF, "calib reset");
		rd(32'hE000E028);
		chk(v1 === 32'h0, "unmapped read");
	endtask
	// Field widths, fixed bits, count clear
	task t_fields;
		wr(RL, 32'hFFFFFFFF);
		rd(RL);
		chk(v1 === 32'h00FFFFFF, "reload width");
		wr(CS, 32'hFFFEFFFA);
		rd(CS);
		chk(v1 === 32'h00000006, "ctrl fields");
		wr(CB, 32'hFFFFFFFF);
		rd(CB);
		chk(v1 === 32'h80FFFFFF, "calib fields");
		wr(CV, 32'hFFFFFFFF);
		rd(CV);
		chk(v1 === 32'h0 && v2 === 32'h0, "count clear");
	endtask
	// Period, mask and interrupt enable
	task t_period;
		wr(RL, 32'h00000009);
		wr(CV, 32'h0);
		wr(CS, 32'h00000003);
		wait_irq(t1);
		wr(IS, 32'h1);
		wait_irq(t2);
		chk(t2 - t1 == 10, "tick period");
		wr(IM, 32'h0);
		wr(IS, 32'h1);
		repeat (12) @(negedge core_clk_i);
		chk(irq_o === 1'b0, "masked interrupt");
		rd(IS);
		chk(v1[0] === 1'b1, "status sticky");
		wr(IM, 32'h1);
		wait_irq(t1);
		wr(CS, 32'h00000001);
		wr(IS, 32'h1);
		repeat (12) @(negedge core_clk_i);
		chk(irq_o === 1'b0, "interrupt disabled");
		rd(CV);
		chk(v2[23:0] === v1[23:0] - 24'h1 || v1[23:0] === 24'h0, "decrement");
	endtask
	// Halt, clock gating and flag clearing
	task t_hold;
		repeat (12) @(negedge core_clk_i);
		@(posedge core_clk_i);
		debug_halt_i <= 1'b1;
		rd(CS);
		chk(v1[16] === 1'b1 && v2[16] === 1'b0, "flag read clear");
		rd(CV);
		chk(v1 === v2, "halt hold");
		@(posedge core_clk_i);
		debug_halt_i <= 1'b0;
		ctrl_clk_stopped_i <= 1'b1;
		rd(CV);
		chk(v1 === v2, "gated hold");
		@(posedge core_clk_i);
		ctrl_clk_stopped_i <= 1'b0;
		repeat (12) @(negedge core_clk_i);
		wr(CV, 32'h12345678);
		rd(CS);
		chk(v1[16] === 1'b0, "flag cleared by count write");
		wr(CS, 32'h0);
	endtask
	// Print counts and verdict
	task final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_fields;
		t_period;
		t_hold;
		final_report;
	end
	// Watchdog, about eighteen times the expected run
	initial begin
		#300000;
		num_errors++;
		final_report;
	end
endmodule // system_tick_timer_tb
`default_nettype wire

// ===== verilog/sticky_bits.v
`timescale 1ns/1ps
`default_nettype none

// Sticky status bits: hardware set wins over a clear in the same cycle
module sticky_bits #(
	parameter W = 1
) (
	// Clock and reset
	input wire core_clk_i,
	input wire reset_n_i,
	// Set and clear requests
	input wire [W-1:0] set_i,
	input wire [W-1:0] clr_i,
	// Held flags
	output wire [W-1:0] flag_o
);

	reg [W-1:0] flag_reg; // Stored flags
	reg [W-1:0] flag_next; // Next flags

	// Set has priority so no event is lost
	always @* begin
		flag_next = (flag_reg & ~clr_i) | set_i;
	end

	// Flag storage
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flag_reg <= {W{1'b0}};
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag_o = flag_reg;

endmodule // sticky_bits

`default_nettype wire

// ===== verilog/system_tick_timer.v
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

`include "system_tick_timer_consts.vh"

module system_tick_timer (
	// Clock and reset
	input wire core_clk_i,
	input wire reset_n_i,
	// Register port
	input wire [31:0] addr_i,
	input wire [31:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output wire [31:0] rdata_o,
	// Processor and power state
	input wire debug_halt_i,
	input wire ctrl_clk_stopped_i,
	// Interrupt
	output wire irq_o
);

	// Address decode
	// Exact word compare; partial addresses select nothing
	// An unselected access reads zero and ignores writes

	reg sel_ctrl; // Control/status selected
	reg sel_reload; // Reload selected
	reg sel_current; // Current value selected
	reg sel_calib; // Calibration selected
	reg sel_irq_status; // Interrupt status selected
	reg sel_irq_mask; // Interrupt mask selected

	// Full word address compare, one select per register
	always @* begin
		sel_ctrl = (addr_i == `TICK_CTRL_STATUS_ADDR);
		sel_reload = (addr_i == `TICK_RELOAD_VALUE_ADDR);
		sel_current = (addr_i == `TICK_CURRENT_VALUE_ADDR);
		sel_calib = (addr_i == `TICK_CALIBRATION_ADDR);
		sel_irq_status = (addr_i == `TICK_IRQ_STATUS_ADDR);
		sel_irq_mask = (addr_i == `TICK_IRQ_MASK_ADDR);
	end

	wire wr_ctrl = wr_i & sel_ctrl; // Control write
	wire wr_reload = wr_i & sel_reload; // Reload write
	wire wr_current = wr_i & sel_current; // Current value write
	wire wr_calib = wr_i & sel_calib; // Calibration write
	wire wr_irq_status = wr_i & sel_irq_status; // Status write, one clears
	wire wr_irq_mask = wr_i & sel_irq_mask; // Mask write
	wire rd_ctrl = rd_i & sel_ctrl; // Control read, has side effect

	// Control/status register
	// Only enable and interrupt enable are stored here
	// Fixed clock source bit and zero flag are added at read

	reg enable_reg; // Counting enable
	reg enable_next;
	reg tick_interrupt_enable_reg; // Tick interrupt enable
	reg tick_interrupt_enable_next;

	// Writable control bits; other bits of the word are dropped
	always @* begin
		enable_next = enable_reg;
		tick_interrupt_enable_next = tick_interrupt_enable_reg;
		if (wr_ctrl) begin
			enable_next = wdata_i[`CTRL_ENABLE_BIT];
			tick_interrupt_enable_next = wdata_i[`CTRL_TICK_IRQ_EN_BIT];
		end
	end

	// Control storage, both bits off after reset
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			enable_reg <= 1'b0;
			tick_interrupt_enable_reg <= 1'b0;
		end else begin
			enable_reg <= enable_next;
			tick_interrupt_enable_reg <= tick_interrupt_enable_next;
		end
	end

	// Reload and calibration registers
	// Reload is taken only at zero, so a new value waits a period
	// Calibration field is writable, its fixed top bits are not stored

	reg [`TICK_COUNT_W-1:0] reload_reg; // Reload value
	reg [`TICK_COUNT_W-1:0] reload_next;
	reg [`TICK_COUNT_W-1:0] ten_ms_reload_value_reg; // Calibration 10 ms value
	reg [`TICK_COUNT_W-1:0] ten_ms_reload_value_next;

	// Only the low 24 bits are stored; upper bits are ignored
	always @* begin
		reload_next = reload_reg;
		ten_ms_reload_value_next = ten_ms_reload_value_reg;
		if (wr_reload) begin
			reload_next = wdata_i[`TICK_COUNT_W-1:0];
		end
		if (wr_calib) begin
			ten_ms_reload_value_next = wdata_i[`TICK_COUNT_W-1:0];
		end
	end

	// Storage with documented reset values
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reload_reg <= `RELOAD_RESET;
			ten_ms_reload_value_reg <= `TEN_MS_RELOAD_RESET;
		end else begin
			reload_reg <= reload_next;
			ten_ms_reload_value_reg <= ten_ms_reload_value_next;
		end
	end

	// Down counter
	// Period is reload plus one running edges
	// Frozen by disable, debug halt or a gated controller clock

	reg [`TICK_COUNT_W-1:0] current_count_reg; // Live count
	reg [`TICK_COUNT_W-1:0] current_count_next;
	reg count_run; // Counter advances this edge
	reg zero_event; // Count steps from one to zero

	// Halt on debug or when the controller clock is stopped
	always @* begin
		count_run = enable_reg & ~debug_halt_i & ~ctrl_clk_stopped_i;
	end

	// Decrement, reload at zero, software write clears
	always @* begin
		current_count_next = current_count_reg;
		zero_event = 1'b0;
		if (wr_current) begin
			// Any write data clears the count, winning over counting
			current_count_next = {`TICK_COUNT_W{1'b0}};
		end else if (count_run) begin
			if (current_count_reg == {`TICK_COUNT_W{1'b0}}) begin
				// At zero the next edge loads the reload value
				current_count_next = reload_reg;
			end else begin
				current_count_next = current_count_reg - {{(`TICK_COUNT_W-1){1'b0}}, 1'b1};
				if (current_count_reg == {{(`TICK_COUNT_W-1){1'b0}}, 1'b1}) begin
					// Transition into zero
					zero_event = 1'b1;
				end
			end
		end
	end

	// Counter storage
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			current_count_reg <= `CURRENT_RESET;
		end else begin
			current_count_reg <= current_count_next;
		end
	end

	// Zero-reached flag
	// Read side effect: a control read clears it
	// Hazard: a zero event in the clearing cycle must survive

	wire zero_reached_flag; // Sticky zero flag
	wire zero_flag_clr; // Flag clear request

	// Cleared by a control read or a current value write
	assign zero_flag_clr = rd_ctrl | wr_current;

	// Set wins over clear so a coincident zero is kept
	sticky_bits #(
		.W(1)
	) zero_flag_u (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.set_i(zero_event),
		.clr_i(zero_flag_clr),
		.flag_o(zero_reached_flag)
	);

	// Interrupt status and mask
	// Status is write-one-to-clear, mask resets open
	// Line is registered, so it lags the status bit by one edge

	wire [`IRQ_W-1:0] irq_status; // Sticky interrupt status
	reg [`IRQ_W-1:0] irq_set; // Status set events
	reg [`IRQ_W-1:0] irq_clr; // Write-one-to-clear
	reg [`IRQ_W-1:0] irq_mask_reg; // Interrupt mask
	reg [`IRQ_W-1:0] irq_mask_next;
	reg irq_reg; // Registered interrupt line
	reg irq_next;

	// Tick event only counts while interrupts are enabled
	always @* begin
		irq_set = {`IRQ_W{1'b0}};
		irq_set[`IRQ_TICK_BIT] = zero_event & tick_interrupt_enable_reg;
		irq_clr = wr_irq_status ? wdata_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}};
	end

	// Status bits, hardware set beats software clear
	sticky_bits #(
		.W(`IRQ_W)
	) irq_status_u (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.set_i(irq_set),
		.clr_i(irq_clr),
		.flag_o(irq_status)
	);

	// Mask update and interrupt level
	always @* begin
		irq_mask_next = irq_mask_reg;
		if (wr_irq_mask) begin
			irq_mask_next = wdata_i[`IRQ_W-1:0];
		end
		// Clearing the enable withdraws a pending tick request
		irq_next = |(irq_status & irq_mask_reg) & tick_interrupt_enable_reg;
	end

	// Mask and interrupt storage
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_mask_reg <= `IRQ_MASK_RESET;
			irq_reg <= 1'b0;
		end else begin
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
		end
	end

	// Read data
	// Idle cycles return zero so read buses can be merged by OR
	// Side effects are keyed to the strobe, not to the data

	reg [31:0] rdata_reg; // Registered read data
	reg [31:0] rdata_next;

	// Read mux; reserved bits and unmapped addresses read zero
	always @* begin
		rdata_next = 32'h00000000;
		if (rd_i) begin
			if (sel_ctrl) begin
				rdata_next[`CTRL_ZERO_FLAG_BIT] = zero_reached_flag;
				rdata_next[`CTRL_CLKSRC_BIT] = `CLKSRC_FIXED;
				rdata_next[`CTRL_TICK_IRQ_EN_BIT] = tick_interrupt_enable_reg;
				rdata_next[`CTRL_ENABLE_BIT] = enable_reg;
			end else if (sel_reload) begin
				rdata_next[`TICK_COUNT_W-1:0] = reload_reg;
			end else if (sel_current) begin
				// Live count as it stands at the read edge
				rdata_next[`TICK_COUNT_W-1:0] = current_count_reg;
			end else if (sel_calib) begin
				rdata_next[`CALIB_NO_REF_CLK_BIT] = `NO_REF_CLK_FIXED;
				rdata_next[`CALIB_SKEW_BIT] = `SKEW_FIXED;
				rdata_next[`TICK_COUNT_W-1:0] = ten_ms_reload_value_reg;
			end else if (sel_irq_status) begin
				rdata_next[`IRQ_W-1:0] = irq_status;
			end else if (sel_irq_mask) begin
				rdata_next[`IRQ_W-1:0] = irq_mask_reg;
			end else begin
				// Unmapped address reads zero
				rdata_next = 32'h00000000;
			end
		end
	end

	// Read data holds only in the cycle after the strobe
	always @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	// Both outputs come straight from flops
	// No decode logic sits between a flop and a pin

	assign rdata_o = rdata_reg; // Straight from flop
	assign irq_o = irq_reg; // Straight from flop

endmodule // system_tick_timer

`default_nettype wire

// ===== verilog/system_tick_timer_consts.vh
`ifndef SYSTEM_TICK_TIMER_CONSTS_VH
`define SYSTEM_TICK_TIMER_CONSTS_VH

// Register byte addresses
`define TICK_CTRL_STATUS_ADDR 32'hE000E010
`define TICK_RELOAD_VALUE_ADDR 32'hE000E014
`define TICK_CURRENT_VALUE_ADDR 32'hE000E018
`define TICK_CALIBRATION_ADDR 32'hE000E01C
`define TICK_IRQ_STATUS_ADDR 32'hE000E020
`define TICK_IRQ_MASK_ADDR 32'hE000E024

// Counter width
`define TICK_COUNT_W 24

// Control/status field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_TICK_IRQ_EN_BIT 1
`define CTRL_CLKSRC_BIT 2
`define CTRL_ZERO_FLAG_BIT 16

// Calibration field positions
`define CALIB_NO_REF_CLK_BIT 31
`define CALIB_SKEW_BIT 30

// Interrupt status/mask layout
`define IRQ_TICK_BIT 0
`define IRQ_W 1

// Reset and fixed values
`define RELOAD_RESET 24'h5F7F9B
`define CURRENT_RESET 24'h7E7F35
`define TEN_MS_RELOAD_RESET 24'hA71FF
`define CLKSRC_FIXED 1'h1
`define NO_REF_CLK_FIXED 1'h1
`define SKEW_FIXED 1'h0
`define IRQ_MASK_RESET 1'h1

// Typical tick period and its cycle count at 10 MHz
`define TICK_PERIOD_NS 10000000
`define CORE_CLK_PERIOD_NS 100
`define TICK_PERIOD_CYCLES (`TICK_PERIOD_NS / `CORE_CLK_PERIOD_NS)

`endif
